// File: rtl/tbadc_control.sv
// Purpose: control side of a ten-bit converter behind a Wishbone slave
// Assumes: analog core is external and returns a ten-bit sample on done
// Notes:   core clock choice and stop-mode gating are outputs to clocking
`timescale 1ns/1ps
`default_nettype none
module tbadc_control
    import tbadc_pkg::*;
#(
    parameter int DW = 32
) (
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [DW-1:0] wb_dat_i,
    output logic      [DW-1:0] wb_dat_o,
    output logic               wb_ack_o,
    input  wire logic          stopMode,
    input  wire logic [9:0]    analogSample,
    input  wire logic          analogReady,
    output logic      [4:0]    analogChannel,
    output logic               analogSampling,
    output logic               clockSourceAsync,
    output logic               converterClockRun,
    output logic      [NUM_PINS-1:0] pinAnalogSelect,
    output logic               convDone
);
    logic [7:0] scReg_q;
    logic [7:0] ckReg_q;
    logic [9:0] result_q;
    logic       done_q;
    logic       ack_q;
    logic [DW-1:0] rdat_q;
    tbadc_state_e state_q;
    logic [3:0] cnt_q;
    logic [4:0] chanRun_q;
    logic [NUM_PINS-1:0] pinSel_q;
    logic       clkSrc_q;
    logic       clkRun_q;
    logic       sampling_q;
    logic [4:0] chanOut_q;
    logic [9:0] memRd;

    // channel decode used for pin map and validity
    function automatic logic [NUM_PINS-1:0] chanToPin(input logic [4:0] c);
        logic [NUM_PINS-1:0] p;
        p = '0;
        if (c < 5'(NUM_PINS)) begin
            p[c[3:0]] = 1'b1;
        end
        return p;
    endfunction

    function automatic logic chanValid(input logic [4:0] c);
        return (c < 5'(NUM_PINS)) || (c == CHAN_BANDGAP);
    endfunction

    // bus decode
    wire        req      = wb_cyc_i & wb_stb_i & ~ack_q;
    wire        lane0    = wb_sel_i[0];
    wire        wrSc     = req & wb_we_i & lane0
                           & (wb_adr_i == OFS_STATUS_CONTROL);
    wire        wrCk     = req & wb_we_i & lane0 & (wb_adr_i == OFS_CLOCK);
    wire        rdLow    = req & ~wb_we_i & (wb_adr_i == OFS_RESULT_LOW);
    wire [4:0]  newChan  = wb_dat_i[SC_CHAN_LSB +: SC_CHAN_W];
    wire        startReq = wrSc & chanValid(newChan);
    wire        mode10   = ckReg_q[CK_MODE10];
    wire        asyncEn  = ckReg_q[CK_ASYNC_EN];
    wire        srcAsync = ckReg_q[CK_SRC_SEL];
    wire        finish   = (state_q == TB_CONV) & analogReady
                           & (cnt_q == 4'h0);
    wire [3:0]  sampLen  = ckReg_q[CK_LSMP] ? LONG_SAMPLE
                                              : SHORT_SAMPLE;
    // eight-bit mode keeps the top eight bits, right justified
    wire [9:0]  modeRes  = mode10 ? analogSample
                                  : {2'b00, analogSample[9:2]};
    // in stop mode the converter runs only while the async clock enable bit is set
    wire        runOk    = ~stopMode | asyncEn;
    wire [7:0]  scRead   = {done_q, scReg_q[6:0]};
    wire [7:0]  rhRead   = {6'h00, result_q[9:8]};
    wire [7:0]  rlRead   = result_q[7:0];
    wire [DW-1:0] rdMux  =
        (wb_adr_i == OFS_STATUS_CONTROL) ? DW'(scRead) :
        (wb_adr_i == OFS_RESULT_HIGH)    ? DW'(rhRead) :
        (wb_adr_i == OFS_RESULT_LOW)     ? DW'(rlRead) :
        (wb_adr_i == OFS_CLOCK)          ? DW'(ckReg_q) :
        (wb_adr_i[7:6] == OFS_SAMPLE_RAM[7:6] + 2'b01) ? DW'(memRd) :
        '0;

    tbadc_result_mem #(
        .WIDTH (10),
        .DEPTH (32),
        .AW    (5)
    ) u_mem (
        .ref_clk (ref_clk),
        .wrEn    (finish),
        .wrAddr  (chanRun_q),
        .wrData  (modeRes),
        .rdAddr  (wb_adr_i[6:2]),
        .rdData  (memRd)
    );

    // registers; separate clock bits so one write path per field
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scReg_q <= {3'b000, CHAN_OFF};
            ckReg_q <= RESET_BYTE;
        end else begin
            if (wrSc) begin
                scReg_q <= {wb_dat_i[6:0] & 7'h7F} == 7'h00 ?
                           8'h00 : {1'b0, wb_dat_i[6:0]};
            end
            if (wrCk) begin
                ckReg_q <= wb_dat_i[7:0];
            end
        end
    end

    // result and done flag: set on finish wins over read clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_q <= 10'h000;
            done_q   <= 1'b0;
        end else begin
            if (finish) begin
                result_q <= modeRes;
                done_q   <= 1'b1;
            end else if (rdLow | wrSc) begin
                done_q   <= 1'b0;
            end
        end
    end

    // sequencer: idle, sample, convert
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= TB_IDLE;
            cnt_q     <= 4'h0;
            chanRun_q <= CHAN_OFF;
        end else begin
            case (state_q)
                TB_IDLE: begin
                    if (startReq & runOk) begin
                        state_q   <= TB_SAMPLE;
                        cnt_q     <= sampLen;
                        chanRun_q <= newChan;
                    end
                end
                TB_SAMPLE: begin
                    if (startReq) begin
                        cnt_q     <= sampLen;
                        chanRun_q <= newChan;
                    end else if (!runOk) begin
                        state_q <= TB_IDLE;
                    end else if (cnt_q == 4'h0) begin
                        state_q <= TB_CONV;
                        cnt_q   <= CONVERT_COUNT;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                TB_CONV: begin
                    if (!runOk) begin
                        state_q <= TB_IDLE;
                    end else if (finish) begin
                        state_q <= TB_IDLE;
                    end else if (cnt_q != 4'h0) begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                default: state_q <= TB_IDLE;
            endcase
        end
    end

    // output flops; pin select only flags the analog tap, never the pad
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinSel_q   <= '0;
            clkSrc_q   <= 1'b0;
            clkRun_q   <= 1'b0;
            sampling_q <= 1'b0;
            chanOut_q  <= CHAN_OFF;
        end else begin
            pinSel_q   <= chanToPin(scReg_q[4:0]);
            clkSrc_q   <= srcAsync;
            clkRun_q   <= (state_q != TB_IDLE) & runOk;
            sampling_q <= (state_q == TB_SAMPLE);
            chanOut_q  <= chanRun_q;
        end
    end

    // bus answer one cycle after request
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q  <= 1'b0;
            rdat_q <= '0;
        end else begin
            ack_q  <= req;
            rdat_q <= req ? rdMux : '0;
        end
    end

    assign wb_ack_o          = ack_q;
    assign wb_dat_o          = rdat_q;
    assign analogChannel     = chanOut_q;
    assign analogSampling    = sampling_q;
    assign clockSourceAsync  = clkSrc_q;
    assign converterClockRun = clkRun_q;
    assign pinAnalogSelect   = pinSel_q;
    assign convDone          = done_q;
endmodule
`default_nettype wire

// File: rtl/tbadc_pkg.sv
// Purpose: constants shared by the ten-bit converter control block
// Assumes: classic Wishbone slave, 8-bit data in low bits of 32-bit bus
// Notes:   register offsets are word aligned byte addresses
package tbadc_pkg;
    localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_RESULT_HIGH    = 8'h04;
    localparam logic [7:0] OFS_RESULT_LOW     = 8'h08;
    localparam logic [7:0] OFS_CLOCK          = 8'h0C;
    localparam logic [7:0] OFS_SAMPLE_RAM     = 8'h10;
    // status/control fields
    localparam int         SC_DONE_BIT   = 7;
    localparam int         SC_CHAN_LSB   = 0;
    localparam int         SC_CHAN_W     = 5;
    // clock register fields
    localparam int         CK_ASYNC_EN   = 0;
    localparam int         CK_MODE10     = 2;
    localparam int         CK_LSMP       = 4;
    localparam int         CK_SRC_SEL    = 5;
    localparam logic [4:0] CHAN_PB0      = 5'h08;
    localparam logic [4:0] CHAN_PB1      = 5'h09;
    localparam logic [4:0] CHAN_BANDGAP  = 5'h1A;
    localparam logic [4:0] CHAN_OFF      = 5'h1F;
    localparam int         NUM_PINS      = 10;
    localparam logic [3:0] SHORT_SAMPLE  = 4'h3;
    localparam logic [3:0] LONG_SAMPLE   = 4'hF;
    localparam logic [3:0] CONVERT_COUNT = 4'hA;
    localparam logic [7:0] RESET_BYTE    = 8'h00;
    typedef enum logic [2:0] {
        TB_IDLE   = 3'b001,
        TB_SAMPLE = 3'b010,
        TB_CONV   = 3'b100
    } tbadc_state_e;
endpackage

// File: rtl/tbadc_result_mem.sv
// Purpose: small per-channel result store with registered read
// Assumes: single clock, one write and one read port
// Notes:   read data valid the cycle after the address
`timescale 1ns/1ps
`default_nettype none
module tbadc_result_mem #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic             ref_clk,
    input  wire logic             wrEn,
    input  wire logic [AW-1:0]    wrAddr,
    input  wire logic [WIDTH-1:0] wrData,
    input  wire logic [AW-1:0]    rdAddr,
    output logic      [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] mem [DEPTH];
    // no reset on the array; an entry never written reads back unknown
    always_ff @(posedge ref_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule
`default_nettype wire

// File: verification/tbadc_control_properties.sv
// Purpose: port-level properties of the converter control block
// Assumes: one clock, asynchronous active-low reset
// Notes:   watches only the top-level ports of the block
`timescale 1ns/1ps
`default_nettype none
module tbadc_control_properties
    import tbadc_pkg::*;
#(
    parameter int DW = 32
) (
    input wire logic                ref_clk,
    input wire logic                rst_n,
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_we_i,
    input wire logic [7:0]          wb_adr_i,
    input wire logic [3:0]          wb_sel_i,
    input wire logic [DW-1:0]       wb_dat_i,
    input wire logic [DW-1:0]       wb_dat_o,
    input wire logic                wb_ack_o,
    input wire logic                analogSampling,
    input wire logic [4:0]          analogChannel,
    input wire logic                clockSourceAsync,
    input wire logic [NUM_PINS-1:0] pinAnalogSelect,
    input wire logic                convDone
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // request phases of a single classic cycle
    sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence hi_rd_s; req_s ##0 (!wb_we_i && wb_adr_i == OFS_RESULT_HIGH);
    endsequence
    sequence ck_wr_s; req_s ##0 (wb_we_i && wb_sel_i[0]
        && wb_adr_i == OFS_CLOCK) ##1 wb_ack_o; endsequence
    ack_follows_req_a: assert property (req_s |=> wb_ack_o)
        else $error("request not acked next cycle");
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    high_upper_zero_a: assert property (
        hi_rd_s |=> wb_dat_o[DW-1:2] == '0)
        else $error("high result upper bits not zero");
    src_bit_sep_a: assert property (
        ck_wr_s |=> clockSourceAsync == $past(wb_dat_i[CK_SRC_SEL]))
        else $error("clock source bit not taken");
    pin_onehot_a: assert property ($onehot0(pinAnalogSelect))
        else $error("more than one pin tapped");
    pin_match_a: assert property (
        analogSampling && analogChannel < 5'(NUM_PINS)
        |-> pinAnalogSelect[analogChannel[3:0]])
        else $error("tapped pin differs from channel");
    bandgap_nopin_a: assert property (
        analogChannel == CHAN_BANDGAP |-> pinAnalogSelect == '0)
        else $error("bandgap selection taps a pin");
    sample_min_a: assert property (
        $rose(analogSampling) |-> analogSampling[*4])
        else $error("sampling phase too short");
    done_after_conv_a: assert property ($rose(convDone) |-> !analogSampling)
        else $error("done raised while sampling");
endmodule
bind tbadc_control tbadc_control_properties #(.DW(DW)) props_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .analogSampling(analogSampling),
    .analogChannel(analogChannel), .clockSourceAsync(clockSourceAsync),
    .pinAnalogSelect(pinAnalogSelect), .convDone(convDone));
`default_nettype wire

// File: verification/tbadc_control_tb.sv
// Purpose: register-level test of the converter control block
// Assumes: every Wishbone request is answered within a few cycles
// Notes:   the analog core is stood in for by a fixed sample
`timescale 1ns/1ps
`default_nettype none
module tbadc_control_tb;
    import tbadc_pkg::*;
    logic                ref_clk = 1'b0;
    logic                rst_n = 1'b0;
    logic                cyc = 1'b0;
    logic                stb = 1'b0;
    logic                we = 1'b0;
    logic [7:0]          adr = 8'h00;
    logic [3:0]          sel = 4'h0;
    logic [31:0]         wdat = 32'h0;
    logic [31:0]         rdat;
    logic                ack;
    logic                stopMode = 1'b0;
    logic [9:0]          sample = 10'h2A5;
    logic                ready = 1'b0;
    logic [4:0]          chan;
    logic                sampling;
    logic                srcAsync;
    logic [NUM_PINS-1:0] pins;
    logic                convDone;
    logic                clkRun;
    logic [3:0]          laneSel = 4'hF;
    logic [31:0]         got;
    int                  bad_count = 0;
    int                  total_checks = 0;
    tbadc_control tbadc_control_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .stopMode(stopMode), .analogSample(sample), .analogReady(ready),
        .analogChannel(chan), .analogSampling(sampling),
        .clockSourceAsync(srcAsync), .converterClockRun(clkRun),
        .pinAnalogSelect(pins), .convDone(convDone));
    // 25 MHz clock
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    // one classic cycle; request held until ack is seen at an edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        int n;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= laneSel;
        wdat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        chk({31'h0, ack}, 32'h1);
        if (ack !== 1'b1) wrap_up();
        got = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // set clock register, start a channel, count the sampling cycles
    task automatic conv(input logic [4:0] ch, input int len,
                        input logic [7:0] ck, input logic expDone);
        int n;
        int s;
        logic [NUM_PINS-1:0] want;
        want = (ch < NUM_PINS) ? (NUM_PINS'(1) << ch) : '0;
        bus(1'b1, OFS_CLOCK, ck);
        bus(1'b1, OFS_STATUS_CONTROL, {3'b000, ch});
        s = 0;
        for (n = 0; n < 200 && convDone !== 1'b1; n++) begin
            @(posedge ref_clk);
            if (sampling === 1'b1) begin
                s++;
                chk({22'h0, pins}, {22'h0, want});
                chk({27'h0, chan}, {27'h0, ch});
                chk({31'h0, clkRun}, 32'h1);
            end
            // ready drops by itself once done is seen, one write per edge
            ready <= (s > 0) && (sampling === 1'b0) && (convDone !== 1'b1);
        end
        chk({31'h0, convDone}, {31'h0, expDone});
        if (expDone) chk(32'(s), 32'(len));
        if (convDone !== expDone) wrap_up();
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        bus(1'b0, OFS_STATUS_CONTROL, 8'h00);
        chk(got, 32'h1F);
        bus(1'b0, OFS_RESULT_HIGH, 8'h00);
        chk(got, 32'h0);
        bus(1'b0, 8'hFC, 8'h00);
        chk(got, 32'h0);
        bus(1'b1, OFS_CLOCK, 8'h01);
        @(posedge ref_clk);
        chk({31'h0, srcAsync}, 32'h0);
        bus(1'b1, OFS_CLOCK, 8'h20);
        @(posedge ref_clk);
        chk({31'h0, srcAsync}, 32'h1);
        bus(1'b0, OFS_CLOCK, 8'h00);
        chk(got, 32'h20);
        // a write without lane zero must leave the clock register alone
        laneSel = 4'hE;
        bus(1'b1, OFS_CLOCK, 8'h00);
        laneSel = 4'hF;
        bus(1'b0, OFS_CLOCK, 8'h00);
        chk(got, 32'h20);
        conv(CHAN_PB0, 16, 8'h14, 1'b1);
        bus(1'b0, OFS_RESULT_HIGH, 8'h00);
        chk(got, 32'h2);
        bus(1'b0, OFS_RESULT_LOW, 8'h00);
        chk(got, 32'hA5);
        chk({31'h0, convDone}, 32'h0);
        conv(CHAN_PB1, 4, 8'h00, 1'b1);
        bus(1'b0, OFS_RESULT_LOW, 8'h00);
        chk(got, 32'hA9);
        for (int c = 0; c < 8; c++) conv(5'(c), 4, 8'h04, 1'b1);
        conv(CHAN_BANDGAP, 4, 8'h04, 1'b1);
        // stop mode: async clock enable keeps it running, without it none starts
        stopMode <= 1'b1;
        conv(CHAN_PB0, 4, 8'h25, 1'b1);
        conv(CHAN_PB0, 0, 8'h24, 1'b0);
        chk({31'h0, clkRun}, 32'h0);
        stopMode <= 1'b0;
        wrap_up();
    end
endmodule
`default_nettype wire
